// ==== hdl/sep_pkg.sv ====
// Constants and types shared by the serial EEPROM command port
package sep_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 25;
  localparam int CS_LOW_MIN_NS    = 250;
  localparam int CS_LOW_CYCLES    = (CS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WORD_PROG_US     = 4000;
  localparam int ERASE_ALL_US     = 8000;
  localparam int WRITE_ALL_US     = 16000;
  localparam int WORD_PROG_CYCLES = WORD_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_ALL_CYCLES = ERASE_ALL_US * 1000 / CLK_PERIOD_NS;
  localparam int WRITE_ALL_CYCLES = WRITE_ALL_US * 1000 / CLK_PERIOD_NS;
  localparam int TMR_W            = 20;
  localparam int CSL_W            = 4;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ARRAY_SMALL      = 0;
  localparam int ARRAY_MID        = 1;
  localparam int ARRAY_LARGE      = 2;
  localparam int ADDR_SMALL_X16   = 6;
  localparam int ADDR_LARGE_X16   = 8;
  localparam int WORDS_SMALL_X16  = 64;
  localparam int WORDS_MID_X16    = 128;
  localparam int WORDS_LARGE_X16  = 256;
  localparam int MEM_BYTES        = 512;
  localparam int MIDX_W           = 9;
  localparam int WORD_W           = 16;
  localparam int BYTE_W           = 8;
  localparam int OP_BITS          = 2;
  localparam int CNT_W            = 5;
  localparam int FIFO_DEPTH       = 32;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ----------------------------------------------------------------
  // Opcodes and special sub-codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ        = 2'h2;
  localparam logic [1:0] OP_WRITE       = 2'h1;
  localparam logic [1:0] OP_ERASE       = 2'h3;
  localparam logic [1:0] OP_SPECIAL     = 2'h0;
  localparam logic [1:0] SUB_ENABLE     = 2'h3;
  localparam logic [1:0] SUB_ERASE_ALL  = 2'h2;
  localparam logic [1:0] SUB_WRITE_ALL  = 2'h1;
  localparam logic [1:0] SUB_DISABLE    = 2'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_READ, ST_DONE} sep_state_t;
  typedef enum logic [2:0] {PG_NONE, PG_ERASE, PG_WRITE, PG_ERASE_ALL, PG_WRITE_ALL} sep_prog_t;

endpackage

// ==== hdl/sep_fifo.sv ====
// Read-ahead FIFO between the array and the serial output shifter
`timescale 1ns/1ps
module sep_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             clear_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid_out = (wr_r != rd_r);
  assign out_data_out  = store_r[rd_r[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      store_r[wr_r[AW-1:0]] <= in_data_in;
    end
  end

  // Clear drops everything; used when the command frame ends
  always_ff @(posedge clk_in) begin
    if (!nrst_in || clear_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

endmodule // sep_fifo

// ==== hdl/sep_cmd_port.sv ====
// Serial EEPROM three-wire command port with array and programming engine
// Behaviour
// - Start bit: first rise with select, input high
// - No operation before a start bit
// - Select high leaves standby at once
// - Execute only after all required bits
// - After last bit, ignore clock until select low
// - Input bits captured on clock rising edge
// - Output high-impedance except read or status
// - Output released on every select falling edge
// - Status low while busy, high when ready
// - Width pin high: 16-bit words, low: 8-bit
// - Opcodes: 10 read, 01 write, 11 erase
// - Special group picks enable, erase-all, write-all, disable
// - Address length set by array and width
// - Wide mode clock counts 25/27 and 9/11
// - Narrow mode clock counts 18/20 and 10/12
// - Read sends dummy zero, then word MSB first
// - Read bits change on clock rising edge
// - Select held high streams following words
// - Power up with programming disabled
// - Enable holds until disable; reads always work
// - Select falling edge starts programming cycle
// - Select low holds control logic in reset
// - Erase sets addressed word to all ones
`timescale 1ns/1ps
module sep_cmd_port
  import sep_pkg::*;
#(
  parameter int ARRAY_KIND     = ARRAY_LARGE,
  parameter int WORD_PROG_CYC  = WORD_PROG_CYCLES,
  parameter int ERASE_ALL_CYC  = ERASE_ALL_CYCLES,
  parameter int WRITE_ALL_CYC  = WRITE_ALL_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic cs_in,
  input  wire logic sclk_in,
  input  wire logic serial_in_pin_in,
  input  wire logic word_width_select_pin_in,
  output logic      serial_out_pin_out,
  output logic      serial_out_oe_n_out,
  output logic      standby_out,
  output logic      busy_out
);
  localparam int A16     = (ARRAY_KIND == ARRAY_SMALL) ? ADDR_SMALL_X16 : ADDR_LARGE_X16;
  localparam int WORDS16 = (ARRAY_KIND == ARRAY_SMALL) ? WORDS_SMALL_X16 :
                           (ARRAY_KIND == ARRAY_MID)   ? WORDS_MID_X16 : WORDS_LARGE_X16;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0]  mem_r [MEM_BYTES];
  sep_state_t         state_r;
  sep_prog_t          pend_r;
  logic               cs_d_r;
  logic               sclk_d_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [1:0]         op_r;
  logic [MIDX_W-1:0]  addr_r;
  logic [WORD_W-1:0]  data_r;
  logic               org_r;
  logic               en_r;
  logic               busy_r;
  logic               walk_r;
  logic               prog_flag_r;
  logic [TMR_W-1:0]   tmr_r;
  logic [MIDX_W-1:0]  widx_r;
  logic [MIDX_W-1:0]  wend_r;
  logic [WORD_W-1:0]  pat_r;
  logic [CSL_W-1:0]   csl_cnt_r;
  logic               pf_act_r;
  logic [MIDX_W-1:0]  pf_addr_r;
  logic [WORD_W-1:0]  sh_r;
  logic [CNT_W-1:0]   rcnt_r;
  logic               stat_r;
  logic               dout_r;
  logic               oe_n_r;
  logic               standby_r;
  logic               sclk_rise;
  logic               cs_fall;
  logic               cs_rise;
  logic               start_c;
  logic [CNT_W-1:0]   alen_c;
  logic [CNT_W-1:0]   dlen_c;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [MIDX_W-1:0]  addr_nxt;
  logic [MIDX_W-1:0]  amask_c;
  logic [MIDX_W-1:0]  waddr_c;
  logic [1:0]         sub_c;
  logic               addr_done;
  logic               data_done;
  logic               pop_c;
  logic [WORD_W-1:0]  pf_word_c;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [WORD_W-1:0]  fifo_out_data;

  // ----------------------------------------------------------------
  // Pin edges and decode helpers
  // ----------------------------------------------------------------
  assign sclk_rise = sclk_in && !sclk_d_r;
  assign cs_fall   = !cs_in && cs_d_r;
  assign cs_rise   = cs_in && !cs_d_r;
  // Start is not accepted while a programming cycle is still running
  assign start_c   = (state_r == ST_IDLE) && cs_in && sclk_rise
                     && serial_in_pin_in && !busy_r;
  assign alen_c    = org_r ? CNT_W'(A16) : CNT_W'(A16 + 1);
  assign dlen_c    = org_r ? CNT_W'(WORD_W) : CNT_W'(BYTE_W);
  assign amask_c   = org_r ? MIDX_W'(WORDS16 - 1) : MIDX_W'(2 * WORDS16 - 1);
  assign cnt_nxt   = cnt_r + 1'b1;
  assign addr_nxt  = {addr_r[MIDX_W-2:0], serial_in_pin_in};
  assign sub_c     = 2'(addr_nxt >> (alen_c - 5'd2));
  // Required counts follow from opcode + address (+ data); the start bit is not counted
  assign addr_done = (state_r == ST_CMD) && sclk_rise
                     && (cnt_nxt == CNT_W'(OP_BITS) + alen_c);
  assign data_done = (state_r == ST_CMD) && sclk_rise
                     && (cnt_nxt == CNT_W'(OP_BITS) + alen_c + dlen_c);
  assign waddr_c   = addr_r & amask_c;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cs_d_r   <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      cs_d_r   <= cs_in;
      sclk_d_r <= sclk_in;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !cs_in) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      op_r    <= '0;
      addr_r  <= '0;
      data_r  <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_c) begin
            state_r <= ST_CMD;
            cnt_r   <= '0;
          end
        end
        ST_CMD: begin
          if (sclk_rise) begin
            cnt_r <= cnt_nxt;
            if (cnt_r < CNT_W'(OP_BITS)) begin
              op_r <= {op_r[0], serial_in_pin_in};
            end else if (cnt_r < CNT_W'(OP_BITS) + alen_c) begin
              addr_r <= addr_nxt;
            end else begin
              data_r <= {data_r[WORD_W-2:0], serial_in_pin_in};
            end
            if (addr_done) begin
              case (op_r)
                OP_READ:    state_r <= ST_READ;
                OP_WRITE:   state_r <= ST_CMD;
                OP_ERASE:   state_r <= ST_DONE;
                default:    state_r <= (sub_c == SUB_WRITE_ALL) ? ST_CMD : ST_DONE;
              endcase
            end else if (data_done) begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_READ: state_r <= ST_READ;
        default: state_r <= ST_DONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program enable latch and pending programming request
  // ----------------------------------------------------------------
  // Only a true power-on reset or a disable command clears the enable; select low does not
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      en_r  <= 1'b0;
      org_r <= 1'b0;
    end else begin
      if (start_c) begin
        org_r <= word_width_select_pin_in;
      end
      if (addr_done && (op_r == OP_SPECIAL)) begin
        if (sub_c == SUB_ENABLE) begin
          en_r <= 1'b1;
        end else if (sub_c == SUB_DISABLE) begin
          en_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in || cs_fall) begin
      pend_r <= PG_NONE;
    end else if (en_r && addr_done && (op_r == OP_ERASE)) begin
      pend_r <= PG_ERASE;
    end else if (en_r && addr_done && (op_r == OP_SPECIAL) && (sub_c == SUB_ERASE_ALL)) begin
      pend_r <= PG_ERASE_ALL;
    end else if (en_r && data_done) begin
      pend_r <= (op_r == OP_WRITE) ? PG_WRITE : PG_WRITE_ALL;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed programming engine
  // ----------------------------------------------------------------
  // The byte walk is far shorter than the timer, so busy ends on the timer
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      busy_r <= 1'b0;
      walk_r <= 1'b0;
      tmr_r  <= '0;
      widx_r <= '0;
      wend_r <= '0;
      pat_r  <= '0;
    end else if (cs_fall && (pend_r != PG_NONE)) begin
      busy_r <= 1'b1;
      walk_r <= 1'b1;
      pat_r  <= ((pend_r == PG_ERASE) || (pend_r == PG_ERASE_ALL)) ? ERASED_WORD :
                (org_r ? data_r : {data_r[BYTE_W-1:0], data_r[BYTE_W-1:0]});
      if ((pend_r == PG_ERASE) || (pend_r == PG_WRITE)) begin
        tmr_r  <= TMR_W'(WORD_PROG_CYC);
        widx_r <= org_r ? {waddr_c[MIDX_W-2:0], 1'b0} : waddr_c;
        wend_r <= org_r ? {waddr_c[MIDX_W-2:0], 1'b1} : waddr_c;
      end else begin
        tmr_r  <= (pend_r == PG_ERASE_ALL) ? TMR_W'(ERASE_ALL_CYC) : TMR_W'(WRITE_ALL_CYC);
        widx_r <= '0;
        wend_r <= MIDX_W'(2 * WORDS16 - 1);
      end
    end else begin
      if (tmr_r != '0) begin
        tmr_r <= tmr_r - 1'b1;
      end
      if (walk_r) begin
        widx_r <= widx_r + 1'b1;
        walk_r <= (widx_r != wend_r);
      end
      busy_r <= (tmr_r > TMR_W'(1)) || (walk_r && (widx_r != wend_r));
    end
  end

  always_ff @(posedge clk_in) begin
    if (walk_r) begin
      mem_r[widx_r] <= widx_r[0] ? pat_r[BYTE_W-1:0] : pat_r[WORD_W-1:BYTE_W];
    end
  end

  // ----------------------------------------------------------------
  // Read-ahead into the FIFO
  // ----------------------------------------------------------------
  // Fetch stalls on a full FIFO; words are ready long before the pin asks
  assign pf_word_c = org_r ? {mem_r[{pf_addr_r[MIDX_W-2:0], 1'b0}],
                              mem_r[{pf_addr_r[MIDX_W-2:0], 1'b1}]}
                           : {mem_r[pf_addr_r], 8'h00};

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !cs_in) begin
      pf_act_r  <= 1'b0;
      pf_addr_r <= '0;
    end else if (addr_done && (op_r == OP_READ)) begin
      pf_act_r  <= 1'b1;
      pf_addr_r <= addr_nxt & amask_c;
    end else if (pf_act_r && fifo_in_ready) begin
      pf_addr_r <= (pf_addr_r + 1'b1) & amask_c;
    end
  end

  sep_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .clear_in      (!cs_in),
    .in_valid_in   (pf_act_r),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (pf_word_c),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (pop_c),
    .out_data_out  (fifo_out_data)
  );

  assign pop_c = (state_r == ST_READ) && sclk_rise && (rcnt_r == '0) && fifo_out_valid;

  // ----------------------------------------------------------------
  // Serial output: read shifter and completion status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      csl_cnt_r   <= '0;
      prog_flag_r <= 1'b0;
    end else begin
      csl_cnt_r <= cs_in ? '0 :
                   (csl_cnt_r == CSL_W'(CS_LOW_CYCLES)) ? csl_cnt_r : csl_cnt_r + 1'b1;
      if (cs_fall && (pend_r != PG_NONE)) begin
        prog_flag_r <= 1'b1;
      end else if (!cs_in && !busy_r) begin
        prog_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !cs_in) begin
      oe_n_r <= 1'b1;
      dout_r <= 1'b0;
      stat_r <= 1'b0;
      sh_r   <= '0;
      rcnt_r <= '0;
    end else if (cs_rise && prog_flag_r && (csl_cnt_r == CSL_W'(CS_LOW_CYCLES))) begin
      stat_r <= 1'b1;
      oe_n_r <= 1'b0;
      dout_r <= !busy_r;
    end else if (stat_r) begin
      // A new start bit ends status reporting
      stat_r <= !start_c;
      oe_n_r <= start_c;
      dout_r <= !busy_r;
    end else if (addr_done && (op_r == OP_READ)) begin
      oe_n_r <= 1'b0;
      dout_r <= 1'b0;
      rcnt_r <= '0;
    end else if ((state_r == ST_READ) && sclk_rise) begin
      if (rcnt_r == '0) begin
        dout_r <= fifo_out_data[WORD_W-1];
        sh_r   <= {fifo_out_data[WORD_W-2:0], 1'b0};
        rcnt_r <= dlen_c - 1'b1;
      end else begin
        dout_r <= sh_r[WORD_W-1];
        sh_r   <= {sh_r[WORD_W-2:0], 1'b0};
        rcnt_r <= rcnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= !cs_in && !busy_r;
    end
  end

  assign serial_out_pin_out  = dout_r;
  assign serial_out_oe_n_out = oe_n_r;
  assign standby_out         = standby_r;
  assign busy_out            = busy_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_enters_cmd: assert property (@(posedge clk_in) disable iff (!nrst_in)
    start_c |=> (state_r == ST_CMD) && (cnt_r == '0))
    else $error("start bit not taken");
  a_idle_no_op: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_IDLE) && !start_c |=> (state_r == ST_IDLE) && (pend_r == $past(pend_r)))
    else $error("activity before start bit caused an operation");
  a_standby_leave: assert property (@(posedge clk_in) disable iff (!nrst_in)
    cs_in |=> !standby_out)
    else $error("standby kept with select high");
  a_done_ignores: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_DONE) && cs_in |=> (state_r == ST_DONE) && $stable(cnt_r))
    else $error("clock not ignored after last bit");
  a_hiz_otherwise: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !serial_out_oe_n_out |-> (state_r == ST_READ) || stat_r)
    else $error("output driven outside read or status");
  a_cs_fall_hiz: assert property (@(posedge clk_in) disable iff (!nrst_in)
    cs_fall |=> serial_out_oe_n_out ##1 serial_out_oe_n_out || cs_in)
    else $error("output not released on select fall");
  a_status_level: assert property (@(posedge clk_in) disable iff (!nrst_in)
    stat_r && $past(stat_r) |-> serial_out_pin_out == !$past(busy_r))
    else $error("status level does not follow busy");
  a_dummy_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    addr_done && (op_r == OP_READ) && !stat_r |=> !serial_out_oe_n_out && !serial_out_pin_out)
    else $error("dummy zero missing");
  a_word_reload: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pop_c |=> rcnt_r == dlen_c - 1'b1)
    else $error("next word not loaded");
  a_locked_prog: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (pend_r != PG_NONE) |-> en_r)
    else $error("programming accepted while disabled");
  a_cs_low_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !cs_in |=> state_r == ST_IDLE)
    else $error("control logic not reset by select low");

endmodule // sep_cmd_port

// ==== sim/sep_host.sv ====
// Host controller model driving the three-wire command port
`timescale 1ns/1ps
module sep_host (
  input  wire logic clk_in,
  input  wire logic dout_in,
  output logic      cs_out,
  output logic      sclk_out,
  output logic      di_out
);
  initial begin
    cs_out = 1'b0;
    sclk_out = 1'b0;
    di_out = 1'b0;
  end
  // Phases of 3 cycles keep clear of the 1-cycle minimum of the sampler
  task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] rd);
    rd = '0;
    cs_out <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      di_out <= bits[i];
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd = {rd[62:0], dout_in};
      sclk_out <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    cs_out <= 1'b0;
    di_out <= ~di_out;
    repeat (12) @(posedge clk_in);
  endtask
  // Bounded wait, so a device stuck busy cannot hang the run
  task automatic poll(output logic st0, output int cyc);
    cs_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    st0 = dout_in;
    cyc = 0;
    while (dout_in !== 1'b1 && cyc < 2000) begin
      @(posedge clk_in);
      cyc++;
    end
    cs_out <= 1'b0;
    repeat (12) @(posedge clk_in);
  endtask
endmodule // sep_host

// ==== sim/sep_cmd_port_bench.sv ====
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ps
module sep_cmd_port_bench;
  import sep_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PROG = 600;
  logic        clk_in, nrst_in, wide_r, cs, sclk, di, dout, oe_n, stby, busy, st0;
  logic [63:0] rd;
  logic [15:0] lfsr_r, w0, w1;
  logic [7:0]  a;
  int          num_errors = 0, samples_checked = 0, cyc, tick = 0;

  sep_cmd_port #(.WORD_PROG_CYC(PROG), .ERASE_ALL_CYC(PROG), .WRITE_ALL_CYC(PROG)) DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .cs_in(cs), .sclk_in(sclk),
    .serial_in_pin_in(di), .word_width_select_pin_in(wide_r),
    .serial_out_pin_out(dout), .serial_out_oe_n_out(oe_n),
    .standby_out(stby), .busy_out(busy));
  // A released output reads as the pull-up level, so a late or missing drive shows up
  sep_host u_host (.clk_in(clk_in), .dout_in(oe_n ? 1'b1 : dout), .cs_out(cs), .sclk_out(sclk),
                   .di_out(di));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [63:0] cmd(logic [1:0] op, logic [8:0] ad, int aw);
    return ((64'h4 | 64'(op)) << aw) | 64'(ad);
  endfunction
  function automatic logic [63:0] wcmd(logic [1:0] op, logic [8:0] ad, logic [15:0] d);
    return (cmd(op, ad, 8) << 16) | 64'(d);
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Two idle rises with input low go ahead of every read's start bit
  task automatic rd_chk(input logic [8:0] ad, input int aw, input int nb, input logic [63:0] e);
    u_host.frame(cmd(OP_READ, ad, aw) << nb, 5 + aw + nb, rd);
    check(rd & ((64'h1 << (nb + 1)) - 64'h1), e);
  endtask
  task automatic prog(input logic [63:0] b, input int n, input logic en);
    u_host.frame(b, n, rd);
    @(posedge clk_in);
    check(busy, en);
    if (en) begin
      u_host.poll(st0, cyc);
      check(st0, 1'b0);
      check(cyc < 2000, 1'b1);
      check(oe_n, 1'b1);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d checked, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    tick <= tick + 1;
    if (tick == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    nrst_in <= 1'b0;
    wide_r <= 1'b1;
    lfsr_r = 16'h001f;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    @(posedge clk_in);
    check({oe_n, stby, busy}, 3'h6);
    lfsr_r = lfsr_next(lfsr_r);
    prog(wcmd(OP_WRITE, 9'(lfsr_r[7:0]), lfsr_r), 27, 1'b0);
    $display("done: locked write");
    // Trailing rises after the last bit must not start anything
    u_host.frame((cmd(OP_SPECIAL, {1'b0, SUB_ENABLE, 6'h00}, 8) << 4) | 64'hb, 15, rd);
    for (int k = 0; k < 2; k++) begin
      lfsr_r = lfsr_next(lfsr_r);
      w0 = lfsr_r;
      lfsr_r = lfsr_next(lfsr_r);
      w1 = lfsr_r;
      a = w1[7:0] ^ w0[15:8];
      prog(wcmd(OP_WRITE, {1'b0, a}, w0), 27, 1'b1);
      prog(wcmd(OP_WRITE, {1'b0, a + 8'h01}, w1), 27, 1'b1);
      rd_chk({1'b0, a}, 8, 32, {w0, w1});
      prog(wcmd(OP_WRITE, {1'b0, a}, ~w0) >> 7, 20, 1'b0);
      wide_r <= 1'b0;
      rd_chk({a, 1'b1}, 9, 8, 64'(w0[7:0]));
      rd_chk({a, 1'b0}, 9, 8, 64'(w0[15:8]));
      wide_r <= 1'b1;
      $display("done: write and read pass %0d", k);
    end
    prog(cmd(OP_SPECIAL, {1'b0, SUB_ERASE_ALL, 6'h00}, 8), 11, 1'b1);
    rd_chk({1'b0, a}, 8, 16, 64'(ERASED_WORD));
    prog(wcmd(OP_SPECIAL, {1'b0, SUB_WRITE_ALL, 6'h00}, w0), 27, 1'b1);
    prog(cmd(OP_ERASE, {1'b0, a}, 8), 11, 1'b1);
    rd_chk({1'b0, a}, 8, 32, {ERASED_WORD, w0});
    $display("done: array-wide commands");
    u_host.frame(cmd(OP_SPECIAL, 9'h000, 8), 11, rd);
    prog(wcmd(OP_WRITE, {1'b0, a}, w1), 27, 1'b0);
    rd_chk({1'b0, a}, 8, 16, 64'(ERASED_WORD));
    check({oe_n, stby, busy}, 3'h6);
    $display("done: disable");
    give_verdict();
  end
endmodule // sep_cmd_port_bench
